// [hw/mseq_pkg.sv]
// Package: microprogram sequencer constants and types
package mseq_pkg;
  // ----------------------------------------------------------------------
  // Control store geometry and word layout
  // ----------------------------------------------------------------------
  localparam int CS_DEPTH = 256;
  localparam int AW = 8;
  localparam int WW = 64;
  localparam int ADR_LSB = 0;
  localparam int BEF_LSB = 8;
  localparam int BEF_W = 3;
  localparam int FEN_LSB = 11;
  localparam int FEN_W = 3;
  localparam int CTL_LSB = 14;
  localparam int CTL_W = WW - CTL_LSB;
  localparam int FEN_A = 0;
  localparam int FEN_B = 1;
  localparam int FEN_C = 2;
  localparam logic [AW-1:0] FORK_MASK = 8'h3f;
  // ----------------------------------------------------------------------
  // Reset values and fixed microaddresses
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0] RESET_UADDR = 8'h00;
  localparam logic [AW-1:0] TRAP_UADDR = 8'h10;
  localparam logic [WW-1:0] NOP_WORD = 64'h0;
  localparam logic [2:0] TIG_LAST = 3'h3;
  // ----------------------------------------------------------------------
  // Trap vectors, highest priority first
  // ----------------------------------------------------------------------
  localparam int NTRAP = 6;
  localparam logic [7:0] VEC_PWR = 8'h08;
  localparam logic [7:0] VEC_ODD = 8'h0c;
  localparam logic [7:0] VEC_STK = 8'h10;
  localparam logic [7:0] VEC_RSV = 8'h14;
  localparam logic [7:0] VEC_INS = 8'h40;
  localparam logic [7:0] VEC_PROGRAMMED_INTERRUPT_REQUEST = 8'h60;
  localparam logic [2:0] BR_BASE_LVL = 3'h4;
  // ----------------------------------------------------------------------
  // APB register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CSIDX = 8'h08;
  localparam logic [7:0] OFS_CSLO = 8'h0c;
  localparam logic [7:0] OFS_CSHI = 8'h10;
  localparam logic [7:0] OFS_VEC = 8'h14;
  localparam logic CTRL_RST = 1'b0;

  typedef enum logic [2:0] {
    BR_NONE = 3'b000,
    BR_DP   = 3'b001,
    BR_CCZN = 3'b010,
    BR_CCVC = 3'b011,
    BR_TRAP = 3'b100,
    BR_CON  = 3'b101,
    BR_BUS  = 3'b110
  } mseq_br_t;
endpackage : mseq_pkg

// [hw/mseq_top.sv]
// Microprogram sequencer with trap/arbitration and timing generator
`timescale 1ns/100ps
module mseq_top (
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [1:0] I_DP_COND,
  input wire logic [3:0] I_CC,
  input wire logic [15:0] I_IR,
  input wire logic I_IR_LOAD,
  input wire logic [7:0] I_SUBROM,
  input wire logic [1:0] I_CONSOLE,
  input wire logic I_CON_STOP,
  input wire logic I_PWR_FAIL,
  input wire logic I_ODD_ADDR,
  input wire logic I_STK_OVF,
  input wire logic I_RSVD_INSTR,
  input wire logic I_TRAP_INSTR,
  input wire logic [2:0] I_TRAP_CODE,
  input wire logic [3:0] I_BUS_REQ,
  input wire logic [2:0] I_CPU_PRI,
  input wire logic I_PROGRAMMED_INTERRUPT_REQUEST_REQ,
  input wire logic [2:0] I_PROGRAMMED_INTERRUPT_REQUEST_PRI,
  input wire logic I_SYS_XFER_REQ,
  input wire logic I_FAST_XFER_REQ,
  output logic [mseq_pkg::CTL_W-1:0] O_CTRL,
  output logic [mseq_pkg::AW-1:0] O_UADDR_PAGE,
  output logic O_TIME_PULSE,
  output logic [7:0] O_TRAP_VEC,
  output logic O_TRAP_TAKEN,
  output logic [3:0] O_BUS_GRANT,
  output logic O_PROGRAMMED_INTERRUPT_REQUEST_GRANT,
  output logic O_CPU_MASTER,
  output logic O_SYS_XFER_GO,
  output logic O_FAST_XFER_GO,
  output logic O_CLK_RUN
);
  import mseq_pkg::*;

  // ----------------------------------------------------------------------
  // Synchronisers for pins from outside the clock domain
  // ----------------------------------------------------------------------
  logic [7:0] sync1_q, sync2_q;
  logic [3:0] breq_s;
  logic [1:0] con_s;
  logic con_stop_s, pwr_s;

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else if (I_CE) begin
      sync1_q <= {I_PWR_FAIL, I_CON_STOP, I_CONSOLE, I_BUS_REQ};
      sync2_q <= sync1_q;
    end
  end
  assign breq_s = sync2_q[3:0];
  assign con_s = sync2_q[5:4];
  assign con_stop_s = sync2_q[6];
  assign pwr_s = sync2_q[7];

  // ----------------------------------------------------------------------
  // Control store, flip-flop storage
  // ----------------------------------------------------------------------
  logic [WW-1:0] cs_q [CS_DEPTH];
  logic [AW-1:0] uaddr_q [3];
  logic [AW-1:0] uaddr_d;
  logic [WW-1:0] cur_word;
  logic [CTL_W-1:0] ctl_q, ctl_d;
  logic cs_we;
  logic [AW-1:0] cs_idx_q, cs_idx_d;
  logic [31:0] cs_lo_q, cs_lo_d;

  // Copies 0 and 1 each address half of the store elements
  assign cur_word = {cs_q[uaddr_q[1]][63:32], cs_q[uaddr_q[0]][31:0]};

  always_ff @(posedge I_MCLK) begin
    if (I_CE && cs_we) begin
      cs_q[cs_idx_q] <= {I_PWDATA, cs_lo_q};
    end
  end

  // ----------------------------------------------------------------------
  // Timing generator
  // ----------------------------------------------------------------------
  logic [2:0] phase_q, phase_d;
  logic tp_q, tp_d, run_q, run_d, ctrl_run_q, ctrl_run_d;
  logic cpu_master_q, stop_now;

  // Console stop, or a system transfer waiting for the bus, stops the timing
  assign stop_now = con_stop_s | (I_SYS_XFER_REQ & ~cpu_master_q);

  always_comb begin
    run_d = ctrl_run_q & ~stop_now;
    phase_d = phase_q;
    tp_d = 1'b0;
    if (run_q) begin
      if (phase_q == TIG_LAST) begin
        phase_d = 3'h0;
        tp_d = 1'b1;
      end else begin
        phase_d = phase_q + 3'h1;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      phase_q <= 3'h0;
      tp_q <= 1'b0;
      run_q <= 1'b0;
    end else if (I_CE) begin
      phase_q <= phase_d;
      tp_q <= tp_d;
      run_q <= run_d;
    end
  end

  // ----------------------------------------------------------------------
  // Trap controller
  // ----------------------------------------------------------------------
  logic [NTRAP-1:0] trap_q, trap_d, trap_clr;
  logic [2:0] tcode_q, tcode_d;
  logic [7:0] vec_q, vec_d;
  logic taken_q, taken_d, trap_any, programmed_interrupt_request_grant_q;

  assign trap_any = |trap_q;

  always_comb begin
    trap_clr = '0;
    vec_d = vec_q;
    taken_d = 1'b0;
    tcode_d = I_TRAP_INSTR ? I_TRAP_CODE : tcode_q;
    if (tp_q && trap_any) begin
      taken_d = 1'b1;
      if (trap_q[0]) begin
        trap_clr[0] = 1'b1;
        vec_d = VEC_PWR;
      end else if (trap_q[1]) begin
        trap_clr[1] = 1'b1;
        vec_d = VEC_ODD;
      end else if (trap_q[2]) begin
        trap_clr[2] = 1'b1;
        vec_d = VEC_STK;
      end else if (trap_q[3]) begin
        trap_clr[3] = 1'b1;
        vec_d = VEC_RSV;
      end else if (trap_q[4]) begin
        trap_clr[4] = 1'b1;
        vec_d = VEC_INS + {3'h0, tcode_q, 2'h0};
      end else begin
        trap_clr[5] = 1'b1;
        vec_d = VEC_PROGRAMMED_INTERRUPT_REQUEST;
      end
    end
    // Set wins over clear for bits 0 to 4; bit 5 is set only while it is not pending
    trap_d = (trap_q & ~trap_clr) | {programmed_interrupt_request_grant_q & ~trap_q[5],
             I_TRAP_INSTR, I_RSVD_INSTR, I_STK_OVF, I_ODD_ADDR, pwr_s};
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      trap_q <= '0;
      tcode_q <= 3'h0;
      vec_q <= 8'h00;
      taken_q <= 1'b0;
    end else if (I_CE) begin
      trap_q <= trap_d;
      tcode_q <= tcode_d;
      vec_q <= vec_d;
      taken_q <= taken_d;
    end
  end

  // ----------------------------------------------------------------------
  // Bus arbitration
  // ----------------------------------------------------------------------
  logic [3:0] grant_q, grant_d;
  logic programmed_interrupt_request_grant_d, cpu_master_d, sys_go_q, sys_go_d, fast_go_q;
  logic [2:0] best_lvl;
  logic hold;

  always_comb begin
    grant_d = '0;
    programmed_interrupt_request_grant_d = 1'b0;
    best_lvl = I_CPU_PRI;
    hold = (|(grant_q & breq_s)) | (programmed_interrupt_request_grant_q & I_PROGRAMMED_INTERRUPT_REQUEST_REQ);
    if (hold) begin
      grant_d = grant_q & breq_s;
      programmed_interrupt_request_grant_d = programmed_interrupt_request_grant_q & I_PROGRAMMED_INTERRUPT_REQUEST_REQ;
    end else begin
      // Only requests above processor priority can win
      if (I_PROGRAMMED_INTERRUPT_REQUEST_REQ && I_PROGRAMMED_INTERRUPT_REQUEST_PRI > best_lvl) begin
        programmed_interrupt_request_grant_d = 1'b1;
        best_lvl = I_PROGRAMMED_INTERRUPT_REQUEST_PRI;
      end
      for (int i = 0; i < 4; i++) begin
        if (breq_s[i] && (BR_BASE_LVL + 3'(i)) > best_lvl) begin
          grant_d = 4'h1 << i;
          programmed_interrupt_request_grant_d = 1'b0;
          best_lvl = BR_BASE_LVL + 3'(i);
        end
      end
    end
    cpu_master_d = ~(|grant_d) & ~programmed_interrupt_request_grant_d;
    sys_go_d = I_SYS_XFER_REQ & cpu_master_q;
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      grant_q <= '0;
      programmed_interrupt_request_grant_q <= 1'b0;
      cpu_master_q <= 1'b1;
      sys_go_q <= 1'b0;
      fast_go_q <= 1'b0;
    end else if (I_CE) begin
      grant_q <= grant_d;
      programmed_interrupt_request_grant_q <= programmed_interrupt_request_grant_d;
      cpu_master_q <= cpu_master_d;
      sys_go_q <= sys_go_d;
      fast_go_q <= I_FAST_XFER_REQ;
    end
  end

  // ----------------------------------------------------------------------
  // Branch, forks and next-address gating
  // ----------------------------------------------------------------------
  logic [AW-1:0] adr_f, fork_tgt, fetch_ir_d;
  logic [15:0] fir_q, fir_d;
  logic [FEN_W-1:0] fen_f;
  logic [1:0] br_mod;
  mseq_br_t bef_f;

  assign adr_f = cur_word[ADR_LSB +: AW];
  assign fen_f = cur_word[FEN_LSB +: FEN_W];
  assign bef_f = mseq_br_t'(cur_word[BEF_LSB +: BEF_W]);
  assign fir_d = I_IR_LOAD ? I_IR : fir_q;

  always_comb begin
    case (bef_f)
      BR_NONE: br_mod = 2'b00;
      BR_DP: br_mod = I_DP_COND;
      BR_CCZN: br_mod = I_CC[3:2];
      BR_CCVC: br_mod = I_CC[1:0];
      BR_TRAP: br_mod = {1'b0, trap_any};
      BR_CON: br_mod = con_s;
      BR_BUS: br_mod = {~cpu_master_q, programmed_interrupt_request_grant_q};
      default: br_mod = 2'b00;
    endcase
    fork_tgt = 8'h00;
    fetch_ir_d = 8'h00;
    if (fen_f[FEN_A]) begin
      fork_tgt = {2'b00, fir_q[15:12], fir_q[5:4]};
    end else if (fen_f[FEN_B]) begin
      fork_tgt = {2'b00, I_SUBROM[2:0], I_IR[5:3]};
    end else if (fen_f[FEN_C]) begin
      fork_tgt = {2'b00, I_SUBROM[5:3], I_IR[11:9]};
    end
    // Forks replace the masked bits; branch bits are ORed after
    if (|fen_f) begin
      fetch_ir_d = (adr_f & ~FORK_MASK) | (fork_tgt & FORK_MASK);
    end else begin
      fetch_ir_d = adr_f;
    end
    fetch_ir_d = fetch_ir_d | {6'h00, br_mod};
    uaddr_d = uaddr_q[0];
    ctl_d = ctl_q;
    if (tp_q) begin
      uaddr_d = trap_any ? TRAP_UADDR : fetch_ir_d;
      ctl_d = cur_word[WW-1:CTL_LSB];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int k = 0; k < 3; k++) begin
        uaddr_q[k] <= RESET_UADDR;
      end
      ctl_q <= NOP_WORD[WW-1:CTL_LSB];
      fir_q <= 16'h0000;
    end else if (I_CE) begin
      for (int k = 0; k < 3; k++) begin
        uaddr_q[k] <= uaddr_d;
      end
      ctl_q <= ctl_d;
      fir_q <= fir_d;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------------
  logic rdy_q, rdy_d, err_q, err_d, acc, hit;
  logic [31:0] rdata_q, rdata_d;

  assign acc = I_PSEL & I_PENABLE & rdy_q;
  assign hit = (I_PADDR <= OFS_VEC) && (I_PADDR[1:0] == 2'b00);

  always_comb begin
    rdy_d = I_PSEL & I_PENABLE & ~rdy_q;
    err_d = rdy_d & ~hit;
    rdata_d = rdata_q;
    ctrl_run_d = ctrl_run_q;
    cs_idx_d = cs_idx_q;
    cs_lo_d = cs_lo_q;
    cs_we = 1'b0;
    if (rdy_d && !I_PWRITE) begin
      case (I_PADDR)
        OFS_CTRL: rdata_d = {31'h0, ctrl_run_q};
        OFS_STATUS: rdata_d = {16'h0, trap_q, run_q,
                               cpu_master_q, uaddr_q[2]};
        OFS_CSIDX: rdata_d = {24'h0, cs_idx_q};
        OFS_CSLO: rdata_d = cs_q[cs_idx_q][31:0];
        OFS_CSHI: rdata_d = cs_q[cs_idx_q][63:32];
        OFS_VEC: rdata_d = {24'h0, vec_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (acc && I_PWRITE) begin
      case (I_PADDR)
        OFS_CTRL: ctrl_run_d = I_PWDATA[0];
        OFS_CSIDX: cs_idx_d = I_PWDATA[AW-1:0];
        OFS_CSLO: cs_lo_d = I_PWDATA;
        // Upper half commits the whole word, so no torn fetch
        OFS_CSHI: cs_we = 1'b1;
        default: cs_we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0;
      ctrl_run_q <= CTRL_RST;
      cs_idx_q <= 8'h00;
      cs_lo_q <= 32'h0;
    end else if (I_CE) begin
      rdy_q <= rdy_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      ctrl_run_q <= ctrl_run_d;
      cs_idx_q <= cs_idx_d;
      cs_lo_q <= cs_lo_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign O_PRDATA = rdata_q;
  assign O_PREADY = rdy_q;
  assign O_PSLVERR = err_q;
  assign O_CTRL = ctl_q;
  assign O_UADDR_PAGE = uaddr_q[2];
  assign O_TIME_PULSE = tp_q;
  assign O_TRAP_VEC = vec_q;
  assign O_TRAP_TAKEN = taken_q;
  assign O_BUS_GRANT = grant_q;
  assign O_PROGRAMMED_INTERRUPT_REQUEST_GRANT = programmed_interrupt_request_grant_q;
  assign O_CPU_MASTER = cpu_master_q;
  assign O_SYS_XFER_GO = sys_go_q;
  assign O_FAST_XFER_GO = fast_go_q;
  assign O_CLK_RUN = run_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);

  AST_ADDR_ONLY_ON_PULSE: assert property (
    (I_CE && !tp_q) |=> uaddr_q[0] == $past(uaddr_q[0]))
    else $error("address moved without a time pulse");
  AST_COPIES_AGREE: assert property (
    uaddr_q[0] == uaddr_q[1] && uaddr_q[1] == uaddr_q[2])
    else $error("address copies differ");
  AST_BUF_LATCH: assert property (
    (I_CE && tp_q) |=> ctl_q == $past(cur_word[WW-1:CTL_LSB]))
    else $error("word buffer missed the new word");
  AST_TRAP_DIVERT: assert property (
    (I_CE && tp_q && trap_any) |=> uaddr_q[0] == TRAP_UADDR && taken_q)
    else $error("pending trap not diverted");
  AST_BRANCH_OR: assert property (
    (I_CE && tp_q && !trap_any && fen_f == '0)
      |=> uaddr_q[0] == $past(adr_f | {6'h00, br_mod}))
    else $error("branch bits not ORed into address");
  AST_FORK_KEEP_HIGH: assert property (
    (I_CE && tp_q && !trap_any && fen_f != '0)
      |=> (uaddr_q[0] & ~FORK_MASK) == $past(adr_f & ~FORK_MASK))
    else $error("fork disturbed unmasked address bits");
  AST_XFER_NEEDS_MASTER: assert property (
    (I_CE && I_SYS_XFER_REQ && !cpu_master_q) |=> !sys_go_q)
    else $error("system transfer without mastership");
  AST_FAST_FREE: assert property (
    (I_CE && I_FAST_XFER_REQ && !cpu_master_q) |=> fast_go_q)
    else $error("fast transfer blocked by bus owner");
  AST_STOP_CLOCK: assert property (
    (I_CE && stop_now) |=> !run_q ##1 (!I_CE || !tp_q))
    else $error("timing did not stop");

  CV_TRAP: cover property (tp_q && trap_any ##1 taken_q);
  CV_FORK_A: cover property (tp_q && fen_f[FEN_A]);
  CV_GRANT: cover property (!cpu_master_q ##1 cpu_master_q);
  CV_STOP: cover property (run_q ##1 !run_q ##[1:20] run_q);
endmodule : mseq_top

// [testbench/mseq_bus_dev.sv]
// System-bus requester model standing beside the sequencer
`timescale 1ns/100ps
module mseq_bus_dev (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_cmd,
  input wire logic [3:0] i_grant,
  input wire logic [7:0] i_hold,
  output logic [3:0] o_req
);
  logic [3:0] done_q;
  logic [7:0] cnt_q;
  // ----------------------------------------------------------------------
  // Request while commanded, give the bus back after i_hold+1 granted cycles
  // ----------------------------------------------------------------------
  assign o_req = i_cmd & ~done_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_q <= 4'h0;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= (|(i_grant & o_req)) ? cnt_q + 8'h01 : 8'h00;
      for (int i = 0; i < 4; i++) begin
        if (!i_cmd[i]) begin
          done_q[i] <= 1'b0;
        end else if (i_grant[i] && cnt_q >= i_hold) begin
          done_q[i] <= 1'b1;
        end
      end
    end
  end
endmodule : mseq_bus_dev

// [testbench/test_mseq_top.sv]
// Self-checking bench for the microprogram sequencer
`timescale 1ns/100ps
module test_mseq_top;
  import mseq_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, ir_load, con_stop, trap_instr;
  logic programmed_interrupt_request_req, sys_req, fast_req, pready, pslverr, err, tpulse;
  logic trap_taken, programmed_interrupt_request_grant, master, sys_go, fast_go, clk_run;
  logic [7:0] paddr, subrom, trap_vec, uaddr, hold;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] dp_cond, con;
  logic ce;
  logic [15:0] ir;
  logic [3:0] flt, bus_req, grant, cmd;
  logic [2:0] trap_code, cpu_pri, programmed_interrupt_request_pri;
  logic [CTL_W-1:0] ctrl;
  int n_mismatch, n_checks, cyc, per;

  mseq_top u_dut (.I_MCLK(clk), .I_ARST_N(rst_n), .I_CE(ce),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DP_COND(dp_cond),
    .I_CC(4'h0), .I_IR(ir), .I_IR_LOAD(ir_load), .I_SUBROM(subrom),
    .I_CONSOLE(con), .I_CON_STOP(con_stop), .I_PWR_FAIL(flt[0]),
    .I_ODD_ADDR(flt[1]), .I_STK_OVF(flt[2]), .I_RSVD_INSTR(flt[3]),
    .I_TRAP_INSTR(trap_instr), .I_TRAP_CODE(trap_code),
    .I_BUS_REQ(bus_req), .I_CPU_PRI(cpu_pri), .I_PROGRAMMED_INTERRUPT_REQUEST_REQ(programmed_interrupt_request_req),
    .I_PROGRAMMED_INTERRUPT_REQUEST_PRI(programmed_interrupt_request_pri), .I_SYS_XFER_REQ(sys_req),
    .I_FAST_XFER_REQ(fast_req), .O_CTRL(ctrl), .O_UADDR_PAGE(uaddr),
    .O_TIME_PULSE(tpulse), .O_TRAP_VEC(trap_vec),
    .O_TRAP_TAKEN(trap_taken), .O_BUS_GRANT(grant),
    .O_PROGRAMMED_INTERRUPT_REQUEST_GRANT(programmed_interrupt_request_grant), .O_CPU_MASTER(master),
    .O_SYS_XFER_GO(sys_go), .O_FAST_XFER_GO(fast_go),
    .O_CLK_RUN(clk_run));

  mseq_bus_dev u_dev (.i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd),
    .i_grant(grant), .i_hold(hold), .o_req(bus_req));

  // ----------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task stop_test();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Holds the request until pready is sampled, for at most 20 cycles
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_mismatch++;
  endtask : apb

  function automatic logic [CTL_W-1:0] ctl_of(input logic [7:0] a);
    return CTL_W'({8'h5a, a, ~a});
  endfunction : ctl_of

  // Store word: control bits, fork enables, branch select, next address
  task wr_cs(input logic [7:0] a, input logic [2:0] fork_enable_field,
             input logic [2:0] bef, input logic [7:0] nxt);
    logic [WW-1:0] w;
    w = {ctl_of(a), fork_enable_field, bef, nxt};
    apb(1'b1, OFS_CSIDX, {24'h0, a});
    apb(1'b1, OFS_CSLO, w[31:0]);
    apb(1'b1, OFS_CSHI, w[63:32]);
    apb(1'b0, OFS_CSLO, 32'h0);
    chk("cs_lo", w[31:0], rd);
    apb(1'b0, OFS_CSHI, 32'h0);
    chk("cs_hi", w[63:32], rd);
  endtask : wr_cs

  // Waits for the load edge; src 8'hff skips the buffered word check
  task step(input logic [7:0] ea, input logic [7:0] src);
    per = 0;
    do begin
      @(posedge clk);
      per++;
    end while (tpulse !== 1'b1 && per < 40);
    #1;
    chk("uaddr", ea, uaddr);
    if (src != 8'hff) chk("ctrl", ctl_of(src), ctrl);
  endtask : step

  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, ir_load, con_stop, trap_instr} = 6'h00;
    {programmed_interrupt_request_req, sys_req, fast_req} = 3'h0;
    {paddr, pwdata, trap_code, programmed_interrupt_request_pri, flt, cmd} = '0;
    dp_cond = 2'b10;
    con = 2'b00;
    ce = 1'b1;
    subrom = 8'h05;
    ir = 16'h5030;
    cpu_pri = 3'h5;
    hold = 8'd20;
    rst_n = 1'b0;
    idle(10);
    chk("rst_uaddr", RESET_UADDR, uaddr);
    chk("rst_ctrl", NOP_WORD[WW-1:CTL_LSB], ctrl);
    chk("rst_master", 1'b1, master);
    chk("rst_run", 1'b0, clk_run);
    @(posedge clk);
    rst_n <= 1'b1;
    ir_load <= 1'b1;
    @(posedge clk);
    ir_load <= 1'b0;
    ir <= 16'h0030;
    wr_cs(8'h00, 3'b000, BR_NONE, 8'h05);
    wr_cs(8'h05, 3'b000, BR_DP, 8'h21);
    wr_cs(8'h23, 3'b001, BR_NONE, 8'h80);
    wr_cs(8'h97, 3'b010, BR_NONE, 8'h40);
    wr_cs(8'h6e, 3'b000, BR_NONE, 8'h6e);
    wr_cs(8'h10, 3'b000, BR_NONE, 8'h10);
    wr_cs(8'hff, 3'b111, BR_BUS, 8'hff);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 1'b1, err);
    chk("unmapped_rd", 32'h0, rd);
    $display("Test store done");
    apb(1'b1, OFS_CTRL, 32'h1);
    ce <= 1'b0;
    idle(10);
    chk("ce_uaddr", 8'h00, uaddr);
    chk("ce_run", 1'b0, clk_run);
    @(posedge clk);
    ce <= 1'b1;
    step(8'h05, 8'h00);
    step(8'h23, 8'h05);
    step(8'h97, 8'h23);
    step(8'h6e, 8'h97);
    step(8'h6e, 8'h6e);
    chk("period", 4, per);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 16'h036e, rd[15:0]);
    $display("Test sequencing done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      flt <= 4'h1 << i;
      idle(3);
      @(posedge clk);
      flt <= 4'h0;
      idle(2);
      step(TRAP_UADDR, 8'hff);
      chk("fault_vec", VEC_PWR + 8'(4 * i), trap_vec);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      trap_instr <= 1'b1;
      trap_code <= 3'(c);
      @(posedge clk);
      trap_instr <= 1'b0;
      step(TRAP_UADDR, TRAP_UADDR);
      chk("instr_vec", VEC_INS + 8'(4 * c), trap_vec);
      chk("taken", 1'b1, trap_taken);
    end
    $display("Test traps done");
    @(posedge clk);
    con_stop <= 1'b1;
    idle(6);
    chk("stop_run", 1'b0, clk_run);
    @(posedge clk);
    con_stop <= 1'b0;
    idle(6);
    chk("restart_run", 1'b1, clk_run);
    $display("Test stop done");
    @(posedge clk);
    con <= 2'b01;
    // Target word first, so the loop never fetches an empty slot
    wr_cs(8'h11, 3'b000, BR_NONE, 8'h11);
    wr_cs(8'h10, 3'b000, BR_CON, 8'h10);
    step(8'h11, 8'h11);
    $display("Test console done");
    @(posedge clk);
    cmd <= 4'b0001;
    idle(8);
    chk("low_grant", 4'h0, grant);
    chk("low_master", 1'b1, master);
    @(posedge clk);
    cmd <= 4'b0101;
    sys_req <= 1'b1;
    fast_req <= 1'b1;
    idle(6);
    chk("grant", 4'b0100, grant);
    chk("master", 1'b0, master);
    chk("sys_go", 1'b0, sys_go);
    chk("fast_go", 1'b1, fast_go);
    chk("held_run", 1'b0, clk_run);
    idle(40);
    chk("back_master", 1'b1, master);
    chk("back_sys_go", 1'b1, sys_go);
    @(posedge clk);
    cmd <= 4'b0001;
    sys_req <= 1'b0;
    programmed_interrupt_request_req <= 1'b1;
    programmed_interrupt_request_pri <= 3'h7;
    idle(8);
    chk("programmed_interrupt_request_grant", 1'b1, programmed_interrupt_request_grant);
    idle(10);
    chk("programmed_interrupt_request_vec", VEC_PROGRAMMED_INTERRUPT_REQUEST, trap_vec);
    $display("Test arbitration done");
    stop_test();
  end
endmodule : test_mseq_top
